// ==== rtl/shs_regs.vh ====
// register map and constants of the shut-height supervisor
// assumes an apb slave with 32-bit data, word-aligned registers
`ifndef SHS_REGS_VH
`define SHS_REGS_VH
`define SHS_ADDR_W       8
`define SHS_OFF_CTRL     8'h00
`define SHS_OFF_UPPER    8'h04
`define SHS_OFF_LOWER    8'h08
`define SHS_OFF_BOLSTER  8'h0C
`define SHS_OFF_TIMEOUT  8'h10
`define SHS_OFF_ACCESS   8'h14
`define SHS_OFF_STATUS   8'h18
`define SHS_OFF_POS      8'h1C
`define SHS_OFF_RAW      8'h20
// control bit positions
`define SHS_CTL_MM       0
`define SHS_CTL_UP_NC    1
`define SHS_CTL_LO_NC    2
`define SHS_CTL_UP_DEEN  3
`define SHS_CTL_LO_DEEN  4
`define SHS_CTL_MOVE_EN  5
`define SHS_CTL_HOLD_EN  6
`define SHS_CTL_ERR_CLR  7
`define SHS_CTL_PROG_EX  8
`define SHS_CTL_RESET    32'h0000_0018
// status bit positions
`define SHS_ST_PROG      0
`define SHS_ST_ERR       1
`define SHS_ST_UP_OUT    2
`define SHS_ST_LO_OUT    3
`define SHS_ST_HOLD      4
`define SHS_ST_TMR       5
`define SHS_ST_UP_PIN    6
`define SHS_ST_LO_PIN    7
// inch thousandths to micrometres: x * 254 / 10
`define SHS_MM_NUM       16'h00FE
`define SHS_MM_DEN       16'h000A
`define SHS_TMO_RESET    32'h0000_0000
`endif

// ==== rtl/shs_limit_out.v ====
// one limit output: comparison, action selection and contact polarity
// assumes position values are signed, in thousandths of an inch
`timescale 1ns/1ps
module shs_limit_out
#(
  parameter POS_W = 32
)
(
  // clock and control
  input  wire             mclk_i,
  input  wire             reset_i,
  input  wire             ce_i,
  // comparison
  input  wire [POS_W-1:0] pos_i,
  input  wire [POS_W-1:0] limit_i,
  input  wire             is_upper_i,
  input  wire             deenergize_i,
  input  wire             nc_i,
  input  wire             fault_i,
  // result
  output reg              beyond_o,
  output reg              pin_o
);
  wire beyond;
  wire energized;

  assign beyond = is_upper_i ? ($signed(pos_i) > $signed(limit_i))
                             : ($signed(pos_i) < $signed(limit_i));
  // coil is energized in normal running under the de-energize action; fault forces the safe state
  assign energized = fault_i ? 1'b0 :
                     (beyond ? ~deenergize_i : deenergize_i); // R1 R5 R12

  always @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      beyond_o <= 1'b0;
      pin_o    <= 1'b0;
    end
    else if (ce_i)
    begin
      beyond_o <= beyond;
      pin_o    <= energized ^ nc_i; // R6
    end
  end
endmodule

// ==== rtl/shs_supervisor.v ====
// shut-height supervisor: apb registers, hold, move timer, limit outputs
// assumes transducer samples arrive synchronous with a one-cycle strobe
// How it works
// R1: a position beyond the upper or lower limit de-energizes that output.
// R2: while hold is asserted the presented position stays frozen.
// R3: after hold drops every new sample refreshes the position again.
// R4: motor drive starts the move timer and detected motion stops it.
// R5: timer expiry before motion de-energizes the limits and flags an error.
// R6: each limit output may be set normally open or normally closed.
// R7: parameters change only in program mode, entered by the access code.
// R8: position is presented in inches or millimetres as configured.
// R9: a bolster offset is added before presentation and comparison.
// R10: positions are carried in thousandths of an inch or finer.
// R11: the auxiliary input acts as motor drive or hold, as enabled.
// R12: the action on reaching a limit is energize or de-energize.
// R13: a sample step over one position unit counts as motion.
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "shs_regs.vh"
module shs_supervisor
#(
  parameter POS_W  = 32,
  parameter [31:0] ACCESS_CODE = 32'h0000_1234 // arbitrary default
)
(
  // clock, reset, enable
  input  wire        mclk_i,
  input  wire        reset_i,
  input  wire        ce_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  // transducer and press
  input  wire [POS_W-1:0] raw_pos_i,
  input  wire        raw_valid_i,
  input  wire        aux_i,
  // outputs
  output reg  [POS_W-1:0] pos_o,
  output reg         upper_pin_o,
  output reg         lower_pin_o,
  output reg         error_o,
  output reg         prog_mode_o
);
  reg  [31:0]      ctrl_q;
  reg  [POS_W-1:0] upper_q;
  reg  [POS_W-1:0] lower_q;
  reg  [POS_W-1:0] bolster_q;
  reg  [31:0]      timeout_q;
  reg              prog_q;
  reg              err_q;
  reg  [POS_W-1:0] prev_raw_q;
  reg              prev_ok_q;
  reg  [POS_W-1:0] held_q;
  reg  [31:0]      tmr_q;
  reg              tmr_run_q;
  reg              aux_q;
  reg              drive_prev_q;
  wire             up_beyond;
  wire             lo_beyond;
  wire             up_pin;
  wire             lo_pin;

  // apb decode helper, used for both read and write
  function is_reg;
    input [7:0] a;
    begin
      case (a)
        `SHS_OFF_CTRL, `SHS_OFF_UPPER, `SHS_OFF_LOWER,
        `SHS_OFF_BOLSTER, `SHS_OFF_TIMEOUT, `SHS_OFF_ACCESS,
        `SHS_OFF_STATUS, `SHS_OFF_POS, `SHS_OFF_RAW: is_reg = 1'b1;
        default: is_reg = 1'b0;
      endcase
    end
  endfunction

  wire setup   = psel_i & ~penable_i;
  wire access  = psel_i & penable_i & pready_o;
  wire wr      = access & pwrite_i & is_reg(paddr_i);
  // parameter registers writable only in program mode
  wire par_wr  = wr & prog_q; // R7
  // write-one command bits are acted on, never stored in ctrl
  wire [31:0] cmd_mask = (32'h0000_0001 << `SHS_CTL_ERR_CLR) |
                         (32'h0000_0001 << `SHS_CTL_PROG_EX);

  // hold and move function share the aux input
  wire hold_act = ctrl_q[`SHS_CTL_HOLD_EN] & aux_q; // R11
  wire drive    = ctrl_q[`SHS_CTL_MOVE_EN] & aux_q; // R11

  // position with bolster offset, thousandths of an inch
  wire [POS_W-1:0] comp_pos = raw_pos_i + bolster_q; // R9 R10
  wire [POS_W-1:0] delta = (raw_pos_i > prev_raw_q) ?
                           raw_pos_i - prev_raw_q : prev_raw_q - raw_pos_i;
  wire [POS_W-1:0] one_unit = {{(POS_W-1){1'b0}}, 1'b1};
  wire moved = raw_valid_i & prev_ok_q & (delta > one_unit); // R13

  // unit conversion; 48-bit product avoids overflow of the scaling
  wire [POS_W+15:0] mm_prod = $signed(held_q) * $signed({1'b0,
                              `SHS_MM_NUM});
  wire [POS_W+15:0] mm_div  = $signed(mm_prod) /
                              $signed({1'b0, `SHS_MM_DEN});
  wire [POS_W-1:0]  shown   = ctrl_q[`SHS_CTL_MM] ?
                              mm_div[POS_W-1:0] : held_q; // R8

  wire [7:0] status = {lower_pin_o, upper_pin_o, tmr_run_q, hold_act,
                       lo_beyond, up_beyond, err_q, prog_q};

  // registers
  always @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ctrl_q    <= `SHS_CTL_RESET;
      upper_q   <= {POS_W{1'b0}};
      lower_q   <= {POS_W{1'b0}};
      bolster_q <= {POS_W{1'b0}};
      timeout_q <= `SHS_TMO_RESET;
      prog_q    <= 1'b0;
    end
    else if (ce_i)
    begin
      if (wr && paddr_i == `SHS_OFF_ACCESS)
        prog_q <= (pwdata_i == ACCESS_CODE); // R7
      else if (wr && paddr_i == `SHS_OFF_CTRL && prog_q &&
               pwdata_i[`SHS_CTL_PROG_EX])
        prog_q <= 1'b0;
      if (par_wr)
      begin
        case (paddr_i)
          `SHS_OFF_CTRL:    ctrl_q    <= pwdata_i & ~cmd_mask;
          `SHS_OFF_UPPER:   upper_q   <= pwdata_i[POS_W-1:0];
          `SHS_OFF_LOWER:   lower_q   <= pwdata_i[POS_W-1:0];
          `SHS_OFF_BOLSTER: bolster_q <= pwdata_i[POS_W-1:0];
          `SHS_OFF_TIMEOUT: timeout_q <= pwdata_i;
          default:          ctrl_q    <= ctrl_q;
        endcase
      end
    end
  end

  // apb answer: no wait state, ready in the first access cycle
  always @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      pready_o  <= setup;
      pslverr_o <= setup & ~is_reg(paddr_i);
      if (setup && !pwrite_i)
      begin
        case (paddr_i)
          `SHS_OFF_CTRL:    prdata_o <= ctrl_q;
          `SHS_OFF_UPPER:   prdata_o <= upper_q;
          `SHS_OFF_LOWER:   prdata_o <= lower_q;
          `SHS_OFF_BOLSTER: prdata_o <= bolster_q;
          `SHS_OFF_TIMEOUT: prdata_o <= timeout_q;
          `SHS_OFF_STATUS:  prdata_o <= {24'h00_0000, status};
          `SHS_OFF_POS:     prdata_o <= shown;
          `SHS_OFF_RAW:     prdata_o <= prev_raw_q;
          default:          prdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // hold, move timer, error
  always @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      aux_q      <= 1'b0;
      prev_raw_q <= {POS_W{1'b0}};
      prev_ok_q  <= 1'b0;
      held_q     <= {POS_W{1'b0}};
      tmr_q      <= 32'h0000_0000;
      tmr_run_q  <= 1'b0;
      err_q      <= 1'b0;
      pos_o      <= {POS_W{1'b0}};
      error_o    <= 1'b0;
      prog_mode_o <= 1'b0;
    end
    else if (ce_i)
    begin
      aux_q <= aux_i;
      if (raw_valid_i)
      begin
        prev_raw_q <= raw_pos_i;
        prev_ok_q  <= 1'b1;
        if (!hold_act)
          held_q <= comp_pos; // R2 R3
      end
      if (drive && !drive_prev_q)
      begin
        tmr_run_q <= 1'b1; // R4
        tmr_q     <= 32'h0000_0000;
      end
      else if (tmr_run_q)
      begin
        if (moved || !drive)
          tmr_run_q <= 1'b0; // R4
        else if (tmr_q >= timeout_q)
        begin
          tmr_run_q <= 1'b0;
          err_q     <= 1'b1; // R5
        end
        else
          tmr_q <= tmr_q + 32'h0000_0001;
      end
      // error set wins over a clear in the same cycle
      if (wr && paddr_i == `SHS_OFF_CTRL && pwdata_i[`SHS_CTL_ERR_CLR]
          && !(tmr_run_q && tmr_q >= timeout_q && !moved && drive))
        err_q <= 1'b0;
      pos_o       <= shown;
      error_o     <= err_q;
      prog_mode_o <= prog_q;
    end
  end

  // rising drive detector state; idles low like drive itself
  always @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      drive_prev_q <= 1'b0;
    else if (ce_i)
      drive_prev_q <= drive;
  end

  // comparison uses the unfrozen compensated position
  reg [POS_W-1:0] live_q;
  always @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      live_q <= {POS_W{1'b0}};
    else if (ce_i && raw_valid_i)
      live_q <= comp_pos; // R9
  end

  shs_limit_out #(.POS_W(POS_W)) u_upper
  (
    .mclk_i       (mclk_i),
    .reset_i      (reset_i),
    .ce_i         (ce_i),
    .pos_i        (live_q),
    .limit_i      (upper_q),
    .is_upper_i   (1'b1),
    .deenergize_i (ctrl_q[`SHS_CTL_UP_DEEN]),
    .nc_i         (ctrl_q[`SHS_CTL_UP_NC]),
    .fault_i      (err_q),
    .beyond_o     (up_beyond),
    .pin_o        (up_pin)
  );

  shs_limit_out #(.POS_W(POS_W)) u_lower
  (
    .mclk_i       (mclk_i),
    .reset_i      (reset_i),
    .ce_i         (ce_i),
    .pos_i        (live_q),
    .limit_i      (lower_q),
    .is_upper_i   (1'b0),
    .deenergize_i (ctrl_q[`SHS_CTL_LO_DEEN]),
    .nc_i         (ctrl_q[`SHS_CTL_LO_NC]),
    .fault_i      (err_q),
    .beyond_o     (lo_beyond),
    .pin_o        (lo_pin)
  );

  always @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      upper_pin_o <= 1'b0;
      lower_pin_o <= 1'b0;
    end
    else if (ce_i)
    begin
      upper_pin_o <= up_pin;
      lower_pin_o <= lo_pin;
    end
  end
endmodule

// ==== bench/shs_checker.sv ====
// port assertions for the shut-height supervisor
// assumes bind onto shs_supervisor, single clock domain
`timescale 1ns/1ps
`include "shs_regs.vh"
module shs_checker
#(
  parameter POS_W = 32
)
(
  // clock and bus
  input wire             mclk_i,
  input wire             reset_i,
  input wire             ce_i,
  input wire             psel_i,
  input wire             penable_i,
  input wire             pwrite_i,
  input wire [7:0]       paddr_i,
  input wire [31:0]      pwdata_i,
  input wire [31:0]      prdata_o,
  input wire             pready_o,
  input wire             pslverr_o,
  // press side
  input wire [POS_W-1:0] raw_pos_i,
  input wire             raw_valid_i,
  input wire             aux_i,
  input wire [POS_W-1:0] pos_o,
  input wire             upper_pin_o,
  input wire             lower_pin_o,
  input wire             error_o,
  input wire             prog_mode_o
);
  wire su = psel_i && !penable_i && ce_i;
  wire wr = psel_i && penable_i && pwrite_i;
  wire clr = wr && paddr_i == `SHS_OFF_CTRL && pwdata_i[`SHS_CTL_ERR_CLR];
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  property p_setup; su |=> pready_o; endproperty
  a_setup: assert property (p_setup)
    else $error("no ready after setup");
  property p_pulse; pready_o |=> !pready_o; endproperty
  a_pulse: assert property (p_pulse)
    else $error("ready held too long");
  property p_errrdy; pslverr_o |-> pready_o; endproperty
  a_errrdy: assert property (p_errrdy)
    else $error("error without ready");
  property p_unmap; su && paddr_i > 8'h20 |=> pslverr_o; endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped access accepted");
  property p_freeze;
    !ce_i |=> $stable(pos_o) && $stable(error_o) && $stable(prog_mode_o);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved with enable low");
  property p_prog;
    $changed(prog_mode_o) |-> $past(wr && (paddr_i == `SHS_OFF_ACCESS
      || paddr_i == `SHS_OFF_CTRL), 2);
  endproperty
  a_prog: assert property (p_prog)
    else $error("program mode changed without write");
  property p_sticky; error_o && !clr && !$past(clr) |=> error_o;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("error dropped without clear");
  property p_cause; $rose(error_o) |-> $past(aux_i, 3);
  endproperty
  a_cause: assert property (p_cause)
    else $error("error without drive");
endmodule
bind shs_supervisor shs_checker #(.POS_W(POS_W)) shs_checker_inst (
  .mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .raw_pos_i(raw_pos_i), .raw_valid_i(raw_valid_i),
  .aux_i(aux_i), .pos_o(pos_o), .upper_pin_o(upper_pin_o),
  .lower_pin_o(lower_pin_o), .error_o(error_o), .prog_mode_o(prog_mode_o));

// ==== bench/shs_xdcr_model.sv ====
// transducer model: strobed samples, steady or stepping
// assumes bench sets base and step between samples
`timescale 1ns/1ps
module shs_xdcr_model
(
  // clock
  input  wire        mclk_i,
  input  wire        reset_i,
  // bench control
  input  wire [31:0] base_i,
  input  wire [31:0] step_i,
  // samples
  output wire [31:0] raw_pos_o,
  output reg         raw_valid_o
);
  reg [31:0] pos_q;
  reg [1:0]  div_q;
  // junk between strobes so stale data is never trusted
  assign raw_pos_o = raw_valid_o ? pos_q : ~pos_q;
  always @(posedge mclk_i or posedge reset_i)
    if (reset_i)
    begin
      div_q <= 2'h0;
      raw_valid_o <= 1'h0;
      pos_q <= 32'h0;
    end
    else
    begin
      div_q <= div_q + 2'h1;
      raw_valid_o <= div_q == 2'h3;
      if (div_q == 2'h3)
        pos_q <= (step_i != 32'h0) ? pos_q + step_i : base_i;
    end
endmodule

// ==== bench/shs_supervisor_test.sv ====
// self-checking bench for the shut-height supervisor
// assumes one-cycle apb answer and the transducer model
`timescale 1ns/1ps
`include "shs_regs.vh"
module shs_supervisor_test;
  localparam [31:0] CODE = 32'h0000_5A3C; // arbitrary
  reg         mclk_i = 1'h0;
  reg         reset_i = 1'h1;
  reg         ce = 1'h1;
  reg         psel = 1'h0;
  reg         pen = 1'h0;
  reg         pwr = 1'h0;
  reg  [7:0]  pa = 8'h00;
  reg  [31:0] pwd = 32'h0;
  reg         aux = 1'h0;
  reg  [31:0] base = 32'h0;
  reg  [31:0] step = 32'h0;
  wire [31:0] prd;
  wire [31:0] rawp;
  wire [31:0] pos;
  wire        prdy, perr, rawv, upin, lpin, err, prog;
  reg  [31:0] rd;
  reg         re;
  integer     fail_count = 0;
  integer     n_tests = 0;
  initial forever #20 mclk_i = ~mclk_i;
  shs_xdcr_model shs_xdcr_model_inst (.mclk_i(mclk_i), .reset_i(reset_i),
    .base_i(base), .step_i(step), .raw_pos_o(rawp), .raw_valid_o(rawv));
  shs_supervisor #(.ACCESS_CODE(CODE)) shs_supervisor_inst (
    .mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
    .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .raw_pos_i(rawp),
    .raw_valid_i(rawv), .aux_i(aux), .pos_o(pos), .upper_pin_o(upin),
    .lower_pin_o(lpin), .error_o(err), .prog_mode_o(prog));
  task chk(input [31:0] got, input [31:0] exp);
  begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
  begin
    @(posedge mclk_i);
    psel <= 1'h1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge mclk_i);
    pen <= 1'h1;
    // no cycle limit here: a hang is ended by the watchdog
    do
      @(posedge mclk_i);
    while (prdy !== 1'h1);
    rd = prd;
    re = perr;
    psel <= 1'h0;
    pen <= 1'h0;
    // outputs lag a write by up to two registers; let them settle
    repeat (3) @(posedge mclk_i);
  end
  endtask
  task drv(input a, input [31:0] b, input [31:0] s, input integer n);
  begin
    @(posedge mclk_i);
    aux <= a;
    base <= b;
    step <= s;
    repeat (n) @(posedge mclk_i);
  end
  endtask
  task summarize;
  begin
    if (fail_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  initial
  begin
    repeat (5000) @(posedge mclk_i);
    fail_count = fail_count + 1;
    summarize;
  end
  initial
  begin
    repeat (10) @(posedge mclk_i);
    reset_i <= 1'h0;
    apb(0, `SHS_OFF_CTRL, 0);
    chk(rd, `SHS_CTL_RESET);
    apb(0, `SHS_OFF_TIMEOUT, 0);
    chk(rd, `SHS_TMO_RESET);
    apb(0, `SHS_OFF_UPPER, 0);
    chk(rd, 32'h0000_0000);
    apb(1, `SHS_OFF_UPPER, 32'h0000_1388);
    apb(0, `SHS_OFF_UPPER, 0);
    chk(rd, 32'h0000_0000);
    apb(0, 8'h40, 0);
    chk(re, 32'h1);
    apb(1, `SHS_OFF_ACCESS, CODE + 32'h1);
    chk(prog, 32'h0);
    apb(1, `SHS_OFF_ACCESS, CODE);
    chk(prog, 32'h1);
    apb(1, `SHS_OFF_UPPER, 32'h0000_1388);
    apb(1, `SHS_OFF_LOWER, 32'h0000_03E8);
    apb(1, `SHS_OFF_BOLSTER, 32'h0000_0064);
    drv(0, 32'h0000_07D0, 0, 12);
    chk(pos, 32'h0000_0834);
    chk({upin, lpin}, 32'h3);
    drv(0, 32'h0000_1356, 0, 12);
    chk({upin, lpin}, 32'h1);
    apb(1, `SHS_OFF_CTRL, 32'h0000_001A);
    chk({upin, lpin}, 32'h3);
    apb(1, `SHS_OFF_CTRL, 32'h0000_0010);
    chk({upin, lpin}, 32'h3);
    drv(0, 32'h0000_07D0, 0, 12);
    chk({upin, lpin}, 32'h1);
    apb(1, `SHS_OFF_CTRL, 32'h0000_0019);
    drv(0, 32'h0000_07D0, 0, 12);
    chk(pos, 32'h0000_D05C);
    apb(1, `SHS_OFF_CTRL, 32'h0000_0018);
    @(posedge mclk_i);
    ce <= 1'h0;
    drv(0, 32'h0000_0BB8, 0, 12);
    chk(pos, 32'h0000_0834);
    @(posedge mclk_i);
    ce <= 1'h1;
    drv(0, 32'h0000_0BB8, 0, 12);
    chk(pos, 32'h0000_0C1C);
    apb(1, `SHS_OFF_CTRL, 32'h0000_0058);
    drv(1, 32'h0000_07D0, 0, 12);
    chk(pos, 32'h0000_0C1C);
    drv(0, 32'h0000_07D0, 0, 12);
    chk(pos, 32'h0000_0834);
    apb(1, `SHS_OFF_TIMEOUT, 32'h0000_0014);
    apb(1, `SHS_OFF_CTRL, 32'h0000_0038);
    drv(1, 32'h0000_07D0, 0, 40);
    chk(err, 32'h1);
    chk({upin, lpin}, 32'h0);
    drv(0, 32'h0000_07D0, 0, 4);
    apb(1, `SHS_OFF_CTRL, 32'h0000_00B8);
    chk(err, 32'h0);
    drv(1, 32'h0000_07D0, 5, 40);
    chk(err, 32'h0);
    drv(0, 32'h0000_07D0, 0, 8);
    drv(1, 32'h0000_07D0, 1, 40);
    chk(err, 32'h1);
    summarize;
  end
endmodule
